// [logic/swpg_top.sv]
// Stop/wait gating of timer, serial interfaces and watchdog
`timescale 1ns/1ns
// Behaviour
// - Stop halts oscillator, CPU, timer, serial, watchdog
// - Stop exits only on interrupt pin or reset
// - Timer holds in stop; reset loads FFFC
// - Interrupt wake resumes timer from held value
// - Capture edge in stop arms, flags after wake
// - Reset exit discards capture armed in stop
// - Serial transmit freezes, resumes after interrupt wake
// - Receive in progress at stop loses rest
// - SPI master freezes in stop, then resumes
// - Reset exit clears SPI control, disables SPI
// - SPI slave keeps shifting during stop
// - Slave completion flag deferred until wake
// - No collision or fault detection in stop
// - Enabled output drivers stay driven in stop
// - Wait halts only CPU clock
// - Wait exits on peripheral interrupt or reset
// - Timer cannot be disabled in wait
// - Interrupt wake keeps state; reset clears all
module swpg_top
    import swpg_pkg::*;
(
    input  wire logic        sys_clk,        // System clock, 25 MHz
    input  wire logic        nrst,           // Hardware reset, active low
    input  wire logic        stop_req,       // CPU executes stop, pulse
    input  wire logic        wait_req,       // CPU executes wait, pulse
    input  wire logic        irq_n_pin,      // External interrupt pin
    input  wire logic        capture_input_pin, // Capture edge input
    input  wire logic        cap_rising,     // Capture edge polarity
    input  wire logic        cap_flag_clr,   // Clear capture flag, pulse
    input  wire logic        sci_enable,     // Serial interface enable
    input  wire logic        sci_tx_start,   // Start transmit, pulse
    input  wire logic [7:0]  sci_tx_data,    // Transmit byte
    input  wire logic        sci_rxd,        // Serial receive pin
    input  wire logic        spi_enable,     // SPI enable
    input  wire logic        spi_master,     // SPI master select
    input  wire logic        spi_write,      // SPI data write, pulse
    input  wire logic [7:0]  spi_wdata,      // SPI write byte
    input  wire logic        spi_flag_clr,   // Clear SPI flags, pulse
    input  wire logic        spi_sck_in,     // SPI clock pin in
    input  wire logic        spi_mosi_in,    // SPI MOSI pin in
    input  wire logic        spi_miso_in,    // SPI MISO pin in
    input  wire logic        spi_ss_n,       // SPI slave select, low
    input  wire logic        wdog_kick,      // Watchdog service, pulse
    input  wire logic        cmp_match_in,   // Compare output level
    output logic             osc_run,        // Internal oscillator on
    output logic             cpu_clk_en,     // CPU clock enable
    output logic             wake_irq,       // Wake by interrupt, pulse
    output logic             wdog_reset,     // Watchdog reset request
    output logic [15:0]      timer_count,    // Free-running timer
    output logic             cap_flag,       // Capture flag
    output logic [15:0]      cap_data,       // Captured timer value
    output logic             sci_txd,        // Serial transmit pin
    output logic [7:0]       sci_rx_data,    // Received byte
    output logic             sci_rx_full,    // Receive done flag
    output logic             spi_sck_out,    // SPI clock pin out
    output logic             spi_sck_oe,     // SPI clock drive enable
    output logic             spi_mosi_out,   // SPI MOSI pin out
    output logic             spi_mosi_oe,    // SPI MOSI drive enable
    output logic             spi_miso_out,   // SPI MISO pin out
    output logic             spi_miso_oe,    // SPI MISO drive enable
    output logic [7:0]       spi_rdata,      // SPI received byte
    output logic             spi_done_flag,  // SPI transfer complete
    output logic             spi_wcol_flag,  // SPI write collision
    output logic             spi_modf_flag,  // SPI mode fault
    output logic             spi_en_state,   // SPI enable held
    output logic             compare_output_pin // Compare output
);
    localparam logic [15:0] WDOG_LIMIT = 16'hFFFF;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic irq_n_s, cap_s, rxd_s, sck_s, mosi_s, miso_s, ss_n_s;

    swpg_sync3 u_irq  (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(irq_n_pin), .dout(irq_n_s));
    swpg_sync3 u_cap  (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(capture_input_pin), .dout(cap_s));
    swpg_sync3 u_rxd  (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(sci_rxd), .dout(rxd_s));
    swpg_sync3 u_sck  (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(spi_sck_in), .dout(sck_s));
    swpg_sync3 u_mosi (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(spi_mosi_in), .dout(mosi_s));
    swpg_sync3 u_miso (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(spi_miso_in), .dout(miso_s));
    swpg_sync3 u_ss   (.sys_clk(sys_clk), .nrst(nrst), .rst_val(1'b1),
                       .din(spi_ss_n), .dout(ss_n_s));

    // ---------------------------------------------------------------
    // Mode control
    // ---------------------------------------------------------------
    swpg_mode_e mode_reg;
    logic       in_stop;
    logic       periph_irq;
    logic       irq_low;

    assign in_stop = (mode_reg == SWPG_STOP);
    assign irq_low = !irq_n_s;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= SWPG_RUN;
        end else begin
            case (mode_reg)
                SWPG_RUN: begin
                    if (stop_req) begin
                        mode_reg <= SWPG_STOP;
                    end else if (wait_req) begin
                        mode_reg <= SWPG_WAIT;
                    end
                end
                SWPG_WAIT: begin
                    if (periph_irq || irq_low) begin
                        mode_reg <= SWPG_RUN;
                    end
                end
                SWPG_STOP: begin
                    if (irq_low) begin
                        mode_reg <= SWPG_RUN;
                    end
                end
                default: mode_reg <= SWPG_RUN;
            endcase
        end
    end

    logic wake_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= in_stop && irq_low;
        end
    end

    assign wake_irq   = wake_reg;
    assign osc_run    = !in_stop;
    assign cpu_clk_en = (mode_reg == SWPG_RUN);

    // ---------------------------------------------------------------
    // Timer and capture
    // ---------------------------------------------------------------
    logic [15:0] tmr_reg;
    logic        cap_prev_reg;
    logic        cap_armed_reg;
    logic [15:0] cap_hold_reg;
    logic        cap_edge;

    // Timer runs in run and wait regardless of any enable
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tmr_reg <= SWPG_TMR_RESET_VAL;
        end else if (!in_stop) begin
            tmr_reg <= tmr_reg + 16'h0001;
        end
    end

    assign cap_edge = (cap_s != cap_prev_reg) && (cap_s == cap_rising);

    // Armed state lives only in flops cleared by reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cap_prev_reg  <= 1'b1;
            cap_armed_reg <= 1'b0;
            cap_hold_reg  <= 16'h0000;
            cap_flag      <= 1'b0;
            cap_data      <= 16'h0000;
        end else begin
            cap_prev_reg <= cap_s;
            if (in_stop) begin
                if (cap_edge && !cap_armed_reg) begin
                    cap_armed_reg <= 1'b1;
                    cap_hold_reg  <= tmr_reg;
                end
            end else if (cap_armed_reg) begin
                cap_armed_reg <= 1'b0;
                cap_flag      <= 1'b1;
                cap_data      <= cap_hold_reg;
            end else if (cap_edge) begin
                cap_flag <= 1'b1;
                cap_data <= tmr_reg;
            end else if (cap_flag_clr) begin
                cap_flag <= 1'b0;
            end
        end
    end

    assign compare_output_pin = cmp_match_in;

    // ---------------------------------------------------------------
    // Asynchronous serial interface
    // ---------------------------------------------------------------
    logic       sci_tick;
    logic [9:0] tx_sh_reg;
    logic [3:0] tx_cnt_reg;
    logic [8:0] rx_sh_reg;
    logic [3:0] rx_cnt_reg;

    swpg_baud #(.DIV(SWPG_BAUD_DIV)) u_sci_baud (
        .sys_clk(sys_clk), .nrst(nrst),
        .run(!in_stop && sci_enable), .tick(sci_tick));

    // Shift state freezes with the baud tick
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_reg  <= 10'h3FF;
            tx_cnt_reg <= 4'h0;
        end else if (sci_tx_start && tx_cnt_reg == 4'h0 && sci_enable) begin
            tx_sh_reg  <= {1'b1, sci_tx_data, 1'b0};
            tx_cnt_reg <= 4'(SWPG_SCI_BITS);
        end else if (sci_tick && tx_cnt_reg != 4'h0) begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sci_txd <= 1'b1;
        end else begin
            sci_txd <= (tx_cnt_reg != 4'h0) ? tx_sh_reg[0] : 1'b1;
        end
    end

    // Partial character is dropped, not resumed
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_sh_reg   <= 9'h000;
            rx_cnt_reg  <= 4'h0;
            sci_rx_data <= 8'h00;
            sci_rx_full <= 1'b0;
        end else if (in_stop) begin
            rx_cnt_reg <= 4'h0;
        end else if (sci_tick) begin
            if (rx_cnt_reg == 4'h0) begin
                if (!rxd_s) begin
                    rx_cnt_reg <= 4'(SWPG_SCI_BITS - 1);
                end
            end else begin
                rx_sh_reg  <= {rxd_s, rx_sh_reg[8:1]};
                rx_cnt_reg <= rx_cnt_reg - 4'h1;
                if (rx_cnt_reg == 4'h1) begin
                    sci_rx_data <= rx_sh_reg[8:1];
                    sci_rx_full <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // SPI
    // ---------------------------------------------------------------
    logic       spi_tick;
    logic [7:0] spi_sh_reg;
    logic [3:0] spi_cnt_reg;
    logic       spi_phase_reg;
    logic       sck_prev_reg;
    logic       slv_done_pend_reg;
    logic       spi_busy;
    logic       mst_mode;
    logic       slv_mode;
    logic       sck_rise;
    logic       sck_fall;

    assign spi_busy = (spi_cnt_reg != 4'h0);
    assign mst_mode = spi_en_state && spi_master;
    assign slv_mode = spi_en_state && !spi_master;
    assign sck_rise = sck_s && !sck_prev_reg;
    assign sck_fall = !sck_s && sck_prev_reg;

    swpg_baud #(.DIV(SWPG_BAUD_DIV)) u_spi_baud (
        .sys_clk(sys_clk), .nrst(nrst),
        .run(!in_stop && mst_mode), .tick(spi_tick));

    // Enable follows spi_enable outside stop and mode fault; hardware reset clears it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spi_en_state <= 1'b0;
        end else if (!in_stop && !spi_modf_flag) begin
            spi_en_state <= spi_enable;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    // Slave edges run even in stop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spi_sh_reg    <= 8'h00;
            spi_cnt_reg   <= 4'h0;
            spi_phase_reg <= 1'b0;
        end else if (spi_write && !spi_busy && !in_stop) begin
            spi_sh_reg    <= spi_wdata;
            spi_cnt_reg   <= 4'(SWPG_SPI_BITS);
            spi_phase_reg <= 1'b0;
        end else if (mst_mode && spi_tick && spi_busy) begin
            spi_phase_reg <= !spi_phase_reg;
            if (spi_phase_reg) begin
                spi_sh_reg  <= {spi_sh_reg[6:0], miso_s};
                spi_cnt_reg <= spi_cnt_reg - 4'h1;
            end
        end else if (slv_mode && !ss_n_s) begin
            if (!spi_busy && sck_rise) begin
                spi_sh_reg  <= {spi_sh_reg[6:0], mosi_s};
                spi_cnt_reg <= 4'(SWPG_SPI_BITS - 1);
            end else if (sck_rise) begin
                spi_sh_reg  <= {spi_sh_reg[6:0], mosi_s};
                spi_cnt_reg <= spi_cnt_reg - 4'h1;
            end
        end
    end

    logic spi_cmpl;
    assign spi_cmpl = spi_busy && (spi_cnt_reg == 4'h1) &&
                      ((mst_mode && spi_tick && spi_phase_reg) ||
                       (slv_mode && !ss_n_s && sck_rise));

    // Flag sets win over software clears
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spi_done_flag     <= 1'b0;
            spi_wcol_flag     <= 1'b0;
            spi_modf_flag     <= 1'b0;
            slv_done_pend_reg <= 1'b0;
            spi_rdata         <= 8'h00;
        end else begin
            if (spi_cmpl) begin
                spi_rdata <= {spi_sh_reg[6:0],
                              mst_mode ? miso_s : mosi_s};
            end
            if (spi_cmpl && in_stop) begin
                slv_done_pend_reg <= 1'b1;
            end else if (!in_stop && slv_done_pend_reg) begin
                slv_done_pend_reg <= 1'b0;
                spi_done_flag     <= 1'b1;
            end else if (spi_cmpl) begin
                spi_done_flag <= 1'b1;
            end else if (spi_flag_clr) begin
                spi_done_flag <= 1'b0;
            end
            if (!in_stop && spi_write && spi_busy) begin
                spi_wcol_flag <= 1'b1;
            end else if (spi_flag_clr) begin
                spi_wcol_flag <= 1'b0;
            end
            if (!in_stop && mst_mode && !ss_n_s) begin
                spi_modf_flag <= 1'b1;
            end else if (spi_flag_clr) begin
                spi_modf_flag <= 1'b0;
            end
        end
    end

    // Drivers stay enabled through stop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spi_sck_out  <= 1'b0;
            spi_mosi_out <= 1'b0;
            spi_miso_out <= 1'b0;
        end else begin
            spi_sck_out  <= spi_phase_reg;
            spi_mosi_out <= spi_sh_reg[7];
            spi_miso_out <= spi_sh_reg[7];
        end
    end

    assign spi_sck_oe  = mst_mode;
    assign spi_mosi_oe = mst_mode;
    assign spi_miso_oe = slv_mode && !ss_n_s;

    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    logic [15:0] wdog_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdog_reg   <= 16'h0000;
            wdog_reset <= 1'b0;
        end else if (wdog_kick) begin
            wdog_reg <= 16'h0000;
        end else if (!in_stop) begin
            wdog_reg   <= wdog_reg + 16'h0001;
            wdog_reset <= (wdog_reg == WDOG_LIMIT - 16'h0001);
        end
    end

    assign periph_irq  = cap_flag || sci_rx_full || spi_done_flag;
    assign timer_count = tmr_reg;
endmodule : swpg_top

// [logic/swpg_pkg.sv]
// Constants and types for the stop/wait peripheral gating block
package swpg_pkg;
    localparam logic [15:0] SWPG_TMR_RESET_VAL = 16'hFFFC;
    localparam int          SWPG_CLK_MHZ       = 25;
    localparam int          SWPG_BAUD_DIV      = 4;
    localparam int          SWPG_SPI_BITS      = 8;
    localparam int          SWPG_SCI_BITS      = 10;
    typedef enum logic [1:0] {
        SWPG_RUN,
        SWPG_WAIT,
        SWPG_STOP
    } swpg_mode_e;
endpackage : swpg_pkg

// [logic/swpg_sync3.sv]
// Three-stage synchroniser with second/third agreement filter
`timescale 1ns/1ns
module swpg_sync3 (
    input  wire logic sys_clk, // System clock
    input  wire logic nrst,    // Async reset, active low
    input  wire logic rst_val, // Unused; reset always loads 1
    input  wire logic din,     // Asynchronous input
    output logic      dout     // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // s1 is read only by s2
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level moves only when stages two and three agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            dout <= s3_reg;
        end
    end

    logic unused_rst_val;
    assign unused_rst_val = rst_val;
endmodule : swpg_sync3

// [logic/swpg_baud.sv]
// Gated baud-rate enable divider
`timescale 1ns/1ns
module swpg_baud #(
    parameter int DIV = 4 // Clock cycles per baud pulse
) (
    input  wire logic sys_clk, // System clock
    input  wire logic nrst,    // Async reset, active low
    input  wire logic run,     // Divider runs while high
    output logic      tick     // One-cycle baud pulse
);
    logic [15:0] cnt_reg;

    // Counter freezes in place while stopped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 16'h0000;
        end else if (run) begin
            if (cnt_reg == 16'(DIV - 1)) begin
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    assign tick = run && (cnt_reg == 16'(DIV - 1));
endmodule : swpg_baud

// [verif/swpg_props.sv]
// Checker for the stop/wait gating block, seen from its top ports
`timescale 1ns/1ns
module swpg_props
    import swpg_pkg::*;
(
    input wire logic        sys_clk,           // Clock
    input wire logic        nrst,              // Reset, low
    input wire logic        stop_req,          // Stop pulse
    input wire logic        wait_req,          // Wait pulse
    input wire logic        osc_run,           // Oscillator on
    input wire logic        cpu_clk_en,        // CPU clock on
    input wire logic        wake_irq,          // Wake pulse
    input wire logic [15:0] timer_count,       // Timer
    input wire logic        cap_flag,          // Capture flag
    input wire logic        sci_txd,           // Serial out
    input wire logic        spi_done_flag,     // SPI done
    input wire logic        spi_wcol_flag,     // Collision
    input wire logic        spi_modf_flag,     // Mode fault
    input wire logic        spi_sck_oe,        // Clock drive
    input wire logic        cmp_match_in,      // Compare level
    input wire logic        compare_output_pin // Compare pin
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Mode entry and exit
    // ------------------------------------------------------------
    a_stop_halts: assert property (
        stop_req && cpu_clk_en |=> !osc_run && !cpu_clk_en)
        else $error("stop did not halt the clocks");
    a_wait_cpu_only: assert property (
        wait_req && !stop_req && cpu_clk_en |=> osc_run && !cpu_clk_en)
        else $error("wait did more than halt the cpu clock");
    a_stop_exit_irq: assert property (
        $rose(osc_run) |-> wake_irq)
        else $error("oscillator restarted without wake");
    a_wake_pulse: assert property (
        wake_irq |-> osc_run && cpu_clk_en ##1 !wake_irq)
        else $error("wake pulse malformed");
    // ------------------------------------------------------------
    // Frozen state in stop
    // ------------------------------------------------------------
    a_timer_held: assert property (
        !osc_run |=> $stable(timer_count))
        else $error("timer moved in stop");
    a_reset_load: assert property (
        disable iff (1'b0) $rose(nrst) |-> timer_count == SWPG_TMR_RESET_VAL)
        else $error("timer not at reset value");
    a_cap_no_flag: assert property (
        !osc_run && !cap_flag |=> !cap_flag)
        else $error("capture flag set in stop");
    a_spi_no_flag: assert property (
        !osc_run && !spi_done_flag |=> !spi_done_flag)
        else $error("spi done set in stop");
    a_prot_off: assert property (
        !osc_run |=> !$rose(spi_wcol_flag) && !$rose(spi_modf_flag))
        else $error("spi protection active in stop");
    a_txd_frozen: assert property (
        !osc_run && $past(!osc_run) |=> $stable(sci_txd))
        else $error("serial output moved in stop");
    a_drive_kept: assert property (
        !osc_run |=> $stable(spi_sck_oe) && compare_output_pin == cmp_match_in)
        else $error("output drive changed in stop");
    c_wake: cover property (wake_irq);
    c_cap: cover property ($rose(cap_flag));
    c_spi: cover property ($rose(spi_done_flag));
endmodule : swpg_props

bind swpg_top swpg_props p_u (.*);

// [verif/swpg_spi_model.sv]
// SPI master on the far side of the slave pins
`timescale 1ns/1ns
module swpg_spi_model (
    input  wire logic sys_clk, // Clock
    input  wire logic miso,    // Slave data back
    output logic      sck,     // Serial clock
    output logic      mosi,    // Master data out
    output logic      ss_n     // Slave select, low
);
    // Clock stands low between frames; long halves beat pin sync
    initial begin
        sck = 1'b0;
        mosi = 1'b1;
        ss_n = 1'b1;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            repeat (8) @(negedge sys_clk);
            sck = 1'b1;
            rx[i] = miso;
            repeat (8) @(negedge sys_clk);
            sck = 1'b0;
        end
        ss_n = 1'b1;
        mosi = ~mosi;
    endtask : xfer
endmodule : swpg_spi_model

// [verif/tb.sv]
// Self-checking bench for the stop/wait gating block
`timescale 1ns/1ns
module tb;
    import swpg_pkg::*;
    logic        sys_clk = 0, nrst = 0, stop_req = 0, wait_req = 0;
    logic        irq_n_pin = 1, capture_input_pin = 0, cap_rising = 1;
    logic        cap_flag_clr = 0, sci_enable = 1, sci_tx_start = 0;
    logic        spi_enable = 0, spi_master = 0, spi_write = 0, loop = 0;
    logic        spi_flag_clr = 0, spi_miso_in = 0, wdog_kick = 0;
    logic        cmp_match_in = 0, sci_rxd, spi_sck_in, spi_mosi_in;
    logic        spi_ss_n, osc_run, cpu_clk_en, wake_irq, wdog_reset;
    logic        cap_flag, sci_txd, sci_rx_full, spi_sck_out, spi_sck_oe;
    logic        spi_mosi_out, spi_mosi_oe, spi_miso_out, spi_miso_oe;
    logic        spi_done_flag, spi_wcol_flag, spi_modf_flag;
    logic        spi_en_state, compare_output_pin;
    logic [7:0]  sci_tx_data = 0, spi_wdata = 0, sci_rx_data, spi_rdata;
    logic [7:0]  got, w, m;
    logic [15:0] timer_count, cap_data, held;
    logic [15:0] cap_q[$], spi_q[$], sci_q[$];
    int          mismatches = 0, n_checks = 0, cyc = 0;

    always #20 sys_clk = ~sys_clk;
    assign sci_rxd = loop ? sci_txd : 1'b1;
    swpg_top dut_u (.*);
    swpg_spi_model pm_u (.sys_clk(sys_clk), .miso(spi_miso_out),
        .sck(spi_sck_in), .mosi(spi_mosi_in), .ss_n(spi_ss_n));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic take(input string what, ref logic [15:0] q[$],
                        input logic [15:0] seen);
        if (q.size() == 0) check({what, " unexpected"}, 16'h0, 16'h1);
        else check(what, q.pop_front(), seen);
    endtask : take
    // Results land a half cycle before they are read
    always @(posedge cap_flag) begin
        @(negedge sys_clk);
        take("cap_data", cap_q, cap_data);
    end
    always @(posedge spi_done_flag) begin
        @(negedge sys_clk);
        take("spi_rdata", spi_q, {8'h0, spi_rdata});
    end
    always @(posedge sci_rx_full) begin
        @(negedge sys_clk);
        take("sci_rx_data", sci_q, {8'h0, sci_rx_data});
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    always @(negedge sys_clk) begin
        wdog_kick <= (cyc % 1000 == 0);
        cmp_match_in <= 1'($urandom);
    end
    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    task automatic cyc_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc_n
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    // Sync of the pin costs a few cycles, so the low is held a while
    task automatic wake;
        irq_n_pin = 1'b0;
        for (int i = 0; i < 20 && cpu_clk_en !== 1'b1; i++) cyc_n(1);
        check("woken", 16'h1, {15'h0, cpu_clk_en});
        irq_n_pin = 1'b1;
        cyc_n(8);
    endtask : wake
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(722));
        cyc_n(3);
        nrst = 1'b1;
        check("timer reset", SWPG_TMR_RESET_VAL, timer_count);
        check("spi reset", 16'h0, {15'h0, spi_en_state});
        cyc_n(5);
        pulse(stop_req);
        held = timer_count;
        cyc_n(10);
        check("timer held", held, timer_count);
        check("osc off", 16'h0, {15'h0, osc_run});
        capture_input_pin = 1'b1;
        cap_q.push_back(held);
        cyc_n(10);
        wake();
        check("resumed", 16'h1, {15'h0, (timer_count - held) inside
            {[16'd1:16'd63]}});
        $display("test stop_irq done");
        capture_input_pin = 1'b0;
        spi_enable = 1'b1;
        cyc_n(8);
        pulse(stop_req);
        capture_input_pin = 1'b1;
        cyc_n(10);
        nrst = 1'b0;
        capture_input_pin = 1'b0;
        cyc_n(1);
        check("spi off", 16'h0, {15'h0, spi_en_state});
        nrst = 1'b1;
        check("timer load", SWPG_TMR_RESET_VAL, timer_count);
        cyc_n(10);
        check("no capture", 16'h0, {15'h0, cap_flag});
        $display("test stop_reset done");
        w = 8'($urandom);
        m = 8'($urandom);
        spi_wdata = w;
        pulse(spi_write);
        cyc_n(4);
        pulse(stop_req);
        pm_u.xfer(m, got);
        pulse(spi_write);
        check("miso byte", {8'h0, w}, {8'h0, got});
        spi_q.push_back({8'h0, m});
        cyc_n(4);
        wake();
        $display("test spi_slave_stop done");
        sci_tx_data = 8'($urandom);
        pulse(sci_tx_start);
        cyc_n(20);
        pulse(stop_req);
        cyc_n(50);
        wake();
        cyc_n(1500);
        check("txd idle", 16'h1, {15'h0, sci_txd});
        pulse(spi_flag_clr);
        loop = 1'b1;
        w = 8'($urandom);
        sci_tx_data = w;
        sci_q.push_back({8'h0, w});
        pulse(sci_tx_start);
        pulse(wait_req);
        held = timer_count;
        cyc_n(20);
        check("wait clocks", 16'h1, {15'h0, osc_run && !cpu_clk_en});
        check("timer runs", 16'h1, {15'h0, timer_count != held});
        for (int i = 0; i < 3000 && sci_rx_full !== 1'b1; i++) cyc_n(1);
        cyc_n(2);
        check("wait exit", 16'h1, {15'h0, cpu_clk_en});
        $display("test wait done");
        tally_and_finish();
    end
endmodule : tb
